/* rtl/imsc_regs.vh */
// register offsets, reset values and decode constants of the memory size block
// Notes on behaviour
// - reset loads program size with cf
// - decode c6/c8/ca/cc/cf as 24..60 kbytes
// - memory beyond selected size stays unmapped
// - reset loads expansion ram size with 0a
// - decode 0c none, 0a 1024 bytes
`ifndef IMSC_REGS_VH
`define IMSC_REGS_VH

// ****************************************
// register map
// ****************************************
`define IMSC_ROM_SIZE_OFF   12'h000
`define IMSC_XRAM_SIZE_OFF  12'h004
`define IMSC_STATUS_OFF     12'h008

// ****************************************
// reset values
// ****************************************
`define IMSC_ROM_SIZE_RST   8'hcf
`define IMSC_XRAM_SIZE_RST  8'h0a

// ****************************************
// program memory size codes and limits in kbytes
// ****************************************
`define IMSC_ROM_24K        8'hc6
`define IMSC_ROM_32K        8'hc8
`define IMSC_ROM_40K        8'hca
`define IMSC_ROM_48K        8'hcc
`define IMSC_ROM_60K        8'hcf
`define IMSC_KB_24          6'd24
`define IMSC_KB_32          6'd32
`define IMSC_KB_40          6'd40
`define IMSC_KB_48          6'd48
`define IMSC_KB_60          6'd60
`define IMSC_KB_EXP_LIMIT   6'd56

// ****************************************
// expansion ram size codes
// ****************************************
`define IMSC_XRAM_NONE      8'h0c
`define IMSC_XRAM_1K        8'h0a
`define IMSC_XRAM_1K_BYTES  11'd1024

// ****************************************
// status register fields
// ****************************************
`define IMSC_ST_ROM_VALID   0
`define IMSC_ST_XRAM_VALID  1
`define IMSC_ST_XRAM_ON     2
`define IMSC_ST_EXP_OK      3

`endif

/* rtl/imsc_size_reg.v */
// one byte-wide size register with reset value and byte-lane write
`timescale 1ns/100ps
module imsc_size_reg #(
	parameter [7:0] RST_VAL = 8'h00
) (
	input  wire       pclk,
	input  wire       presetn,
	input  wire       wr_en,
	input  wire [3:0] pstrb,
	input  wire [7:0] wdata,
	output reg  [7:0] value_q
);

	// only lane 0 updates the byte; a write without it leaves the value alone
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			value_q <= RST_VAL;
		end else if (wr_en && pstrb[0]) begin
			value_q <= wdata;
		end
	end

endmodule

/* rtl/imsc_top.v */
// apb register bank selecting mapped program flash and expansion ram size
`timescale 1ns/100ps
`include "imsc_regs.vh"
module imsc_top (
	input  wire        pclk,
	input  wire        presetn,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	input  wire [3:0]  pstrb,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	input  wire [15:0] mem_addr,
	input  wire        ext_exp_en,
	output reg  [5:0]  rom_size_kb,
	output reg  [10:0] xram_size_bytes,
	output reg         rom_hit,
	output reg         rom_code_valid,
	output reg         xram_code_valid
);

	// ****************************************
	// bus decode
	// ****************************************
	wire        setup_ph;
	wire        sel_rom;
	wire        sel_xram;
	wire        sel_stat;
	wire        mapped;
	wire        wr_rom;
	wire        wr_xram;
	wire [7:0]  rom_q;
	wire [7:0]  xram_q;
	reg  [5:0]  rom_kb_d;
	reg         rom_ok_d;
	reg  [10:0] xram_d;
	reg         xram_ok_d;
	reg         ext_s1_q;
	reg         ext_s2_q;
	reg  [31:0] rdata_d;

	assign setup_ph = psel && !penable;
	assign sel_rom  = (paddr == `IMSC_ROM_SIZE_OFF);
	assign sel_xram = (paddr == `IMSC_XRAM_SIZE_OFF);
	assign sel_stat = (paddr == `IMSC_STATUS_OFF);
	assign mapped   = sel_rom | sel_xram | sel_stat;
	// writes land at the access edge; the decode sees them at once, the registered map outputs one cycle later
	assign wr_rom   = psel && penable && pready && pwrite && sel_rom;
	assign wr_xram  = psel && penable && pready && pwrite && sel_xram;

	// ****************************************
	// size registers
	// ****************************************
	imsc_size_reg #(
		.RST_VAL (`IMSC_ROM_SIZE_RST)
	) u_rom_size (
		.pclk    (pclk),
		.presetn (presetn),
		.wr_en   (wr_rom),
		.pstrb   (pstrb),
		.wdata   (pwdata[7:0]),
		.value_q (rom_q)
	);

	imsc_size_reg #(
		.RST_VAL (`IMSC_XRAM_SIZE_RST)
	) u_xram_size (
		.pclk    (pclk),
		.presetn (presetn),
		.wr_en   (wr_xram),
		.pstrb   (pstrb),
		.wdata   (pwdata[7:0]),
		.value_q (xram_q)
	);

	// ****************************************
	// size decode
	// ****************************************
	// unknown codes map nothing rather than guess a size
	always @* begin
		rom_ok_d = 1'b1;
		case (rom_q)
			`IMSC_ROM_24K: rom_kb_d = `IMSC_KB_24;
			`IMSC_ROM_32K: rom_kb_d = `IMSC_KB_32;
			`IMSC_ROM_40K: rom_kb_d = `IMSC_KB_40;
			`IMSC_ROM_48K: rom_kb_d = `IMSC_KB_48;
			`IMSC_ROM_60K: rom_kb_d = `IMSC_KB_60;
			default: begin
				rom_kb_d = 6'd0;
				rom_ok_d = 1'b0;
			end
		endcase
	end

	always @* begin
		xram_ok_d = 1'b1;
		case (xram_q)
			`IMSC_XRAM_NONE: xram_d = 11'd0;
			`IMSC_XRAM_1K:   xram_d = `IMSC_XRAM_1K_BYTES;
			default: begin
				xram_d    = 11'd0;
				xram_ok_d = 1'b0;
			end
		endcase
	end

	// ****************************************
	// pin synchroniser for the expansion strap
	// ****************************************
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ext_s1_q <= 1'b0;
			ext_s2_q <= 1'b0;
		end else begin
			ext_s1_q <= ext_exp_en;
			ext_s2_q <= ext_s1_q;
		end
	end

	// ****************************************
	// memory map outputs
	// ****************************************
	// registered so the map changes cleanly one cycle after a write
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rom_size_kb     <= `IMSC_KB_60;
			xram_size_bytes <= `IMSC_XRAM_1K_BYTES;
			rom_code_valid  <= 1'b1;
			xram_code_valid <= 1'b1;
			rom_hit         <= 1'b0;
		end else begin
			rom_size_kb     <= rom_kb_d;
			xram_size_bytes <= xram_d;
			rom_code_valid  <= rom_ok_d;
			xram_code_valid <= xram_ok_d;
			// above the selected size the address is not internal
			rom_hit         <= ({4'h0, mem_addr[15:10]} < {4'h0, rom_size_kb});
		end
	end

	// ****************************************
	// read mux
	// ****************************************
	always @* begin
		rdata_d = 32'h0000_0000;
		if (sel_rom) begin
			rdata_d = {24'h00_0000, rom_q};
		end else if (sel_xram) begin
			rdata_d = {24'h00_0000, xram_q};
		end else if (sel_stat) begin
			rdata_d[`IMSC_ST_ROM_VALID]  = rom_ok_d;
			rdata_d[`IMSC_ST_XRAM_VALID] = xram_ok_d;
			rdata_d[`IMSC_ST_XRAM_ON]    = (xram_d != 11'd0);
			// set while the map leaves room for external devices or the expansion strap is off
			rdata_d[`IMSC_ST_EXP_OK]     = !ext_s2_q || (rom_kb_d < `IMSC_KB_EXP_LIMIT);
		end
	end

	// ****************************************
	// apb answer: no wait state, ready in the first access cycle
	// ****************************************
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= setup_ph;
			pslverr <= setup_ph && !mapped;
			if (setup_ph && !pwrite) begin
				prdata <= rdata_d;
			end
		end
	end

endmodule

/* bench/imsc_chk.sv */
// assertion checker for the memory size register bank
`timescale 1ns/100ps
module imsc_chk (
	input logic        pclk,
	input logic        presetn,
	input logic        psel,
	input logic        penable,
	input logic        pwrite,
	input logic [11:0] paddr,
	input logic [31:0] pwdata,
	input logic [3:0]  pstrb,
	input logic        pready,
	input logic [15:0] mem_addr,
	input logic [5:0]  rom_size_kb,
	input logic [10:0] xram_size_bytes,
	input logic        rom_hit
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// completed lane-0 writes; other lanes never count
	wire wr  = psel & penable & pwrite & pready & pstrb[0];
	wire wr0 = wr & (paddr == 12'h000);
	wire wr4 = wr & (paddr == 12'h004);
	// undocumented codes map nothing
	function automatic [5:0] kb(input [7:0] c);
		case (c)
		8'hc6: kb = 6'd24;
		8'hc8: kb = 6'd32;
		8'hca: kb = 6'd40;
		8'hcc: kb = 6'd48;
		8'hcf: kb = 6'd60;
		default: kb = 6'd0;
		endcase
	endfunction
	property p_rom_rst; $rose(presetn) |-> rom_size_kb == 6'd60; endproperty
	a_rom_rst: assert property (p_rom_rst) else $error("rom size not 60k after reset");
	property p_xram_rst; $rose(presetn) |-> xram_size_bytes == 11'd1024; endproperty
	a_xram_rst: assert property (p_xram_rst) else $error("xram not 1024 after reset");
	property p_rom_code; wr0 |-> ##2 rom_size_kb == kb($past(pwdata[7:0], 2)); endproperty
	a_rom_code: assert property (p_rom_code) else $error("rom size decode wrong");
	property p_xram_code;
		wr4 |-> ##2 xram_size_bytes == (($past(pwdata[7:0], 2) == 8'h0a) ? 11'd1024 : 11'd0);
	endproperty
	a_xram_code: assert property (p_xram_code) else $error("xram size decode wrong");
	property p_hit;
		$past(presetn) |-> rom_hit == ($past(mem_addr) < {$past(rom_size_kb), 10'h000});
	endproperty
	a_hit: assert property (p_hit) else $error("rom hit wrong");
	property p_hold; !$past(wr0, 2) |-> $stable(rom_size_kb); endproperty
	a_hold: assert property (p_hold) else $error("rom size moved without write");
	c_rom_wr: cover property (wr0);
	c_xram_wr: cover property (wr4);
	c_hit: cover property (rom_hit);
endmodule
bind imsc_top imsc_chk i_chk (.*);

/* bench/tb_internal_memory_size_config.sv */
// self-checking bench for the memory size register bank
`timescale 1ns/100ps
module tb_internal_memory_size_config;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er, ext_exp_en;
	logic        rom_hit, rom_code_valid, xram_code_valid;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0]  pstrb;
	logic [15:0] mem_addr;
	logic [5:0]  rom_size_kb;
	logic [10:0] xram_size_bytes;
	int          n_fail = 0, n_tests = 0;
	imsc_top i_dut (.*);
	// ******
	// clock and helpers
	// ******
	initial begin
		pclk = 0;
		forever #10 pclk = ~pclk;
	end
	task final_report;
		$display("tests %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task chk(input string n, input logic [31:0] s, input logic [31:0] e);
		n_tests++;
		if (s !== e) begin
			n_fail++;
			$display("CHECK FAILED %s exp %h got %h", n, e, s);
		end
	endtask
	task wt;
		repeat (2) @(posedge pclk);
	endtask
	// apb transfer; waits on pready since the slave sets the pace
	task apb(input logic w, input logic [11:0] a, input logic [7:0] d, input logic [3:0] s);
		int i;
		@(posedge pclk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		pstrb <= s;
		@(posedge pclk);
		penable <= 1;
		i = 0;
		do begin
			@(posedge pclk);
			i++;
		end while (pready !== 1'b1 && i < 16);
		if (pready !== 1'b1) begin
			n_fail++;
			final_report;
		end
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	// ******
	// scenarios
	// ******
	task t_reset;
		@(posedge pclk);
		presetn <= 0;
		repeat (4) @(posedge pclk);
		presetn <= 1;
		wt;
		chk("rom kb", rom_size_kb, 60);
		chk("xram", xram_size_bytes, 1024);
		apb(0, 12'h000, 8'h00, 4'h1);
		chk("rom rd", rd, 32'hcf);
		apb(0, 12'h004, 8'h00, 4'h1);
		chk("xram rd", rd, 32'h0a);
	endtask
	// every code back to back, with the hit edge probed on both sides
	task t_rom;
		logic [7:0] c[5] = '{8'hc6, 8'hc8, 8'hca, 8'hcc, 8'hcf};
		int         k[5] = '{24, 32, 40, 48, 60};
		for (int i = 0; i < 5; i++) begin
			apb(1, 12'h000, c[i], 4'h1);
			apb(0, 12'h000, 8'h00, 4'h1);
			chk("rom rd", rd, {24'h0, c[i]});
			chk("rom kb", rom_size_kb, k[i]);
			mem_addr <= 16'(k[i] * 1024 - 1);
			wt;
			chk("hit in", rom_hit, 1);
			mem_addr <= 16'(k[i] * 1024);
			wt;
			chk("hit out", rom_hit, 0);
		end
		apb(1, 12'h000, 8'h55, 4'h1);
		wt;
		chk("rom odd", rom_size_kb, 0);
		chk("rom code bad", rom_code_valid, 0);
		apb(1, 12'h000, 8'hc6, 4'h0);
		wt;
		chk("rom kept", rom_size_kb, 0);
		ext_exp_en <= 1;
		apb(1, 12'h000, 8'hcc, 4'h1);
		wt;
		chk("rom 48", rom_size_kb, 48);
		chk("rom code ok", rom_code_valid, 1);
		chk("wr err", er, 0);
		apb(0, 12'h008, 8'h00, 4'h1);
		chk("status 48k", rd, 32'h0000_000f);
		apb(1, 12'h000, 8'hcf, 4'h1);
		apb(0, 12'h008, 8'h00, 4'h1);
		chk("status 60k", rd, 32'h0000_0007);
		apb(1, 12'h000, 8'hcc, 4'h1);
		wt;
		chk("rom 48 again", rom_size_kb, 48);
	endtask
	task t_xram;
		apb(1, 12'h004, 8'h0c, 4'h1);
		wt;
		chk("xram off", xram_size_bytes, 0);
		apb(1, 12'h004, 8'h0a, 4'h1);
		wt;
		chk("xram on", xram_size_bytes, 1024);
		chk("xram code ok", xram_code_valid, 1);
		apb(1, 12'h004, 8'h33, 4'h1);
		wt;
		chk("xram odd", xram_size_bytes, 0);
		chk("xram code bad", xram_code_valid, 0);
		apb(1, 12'h004, 8'h0a, 4'h1);
		wt;
		chk("xram back", xram_size_bytes, 1024);
		apb(1, 12'h00c, 8'hc6, 4'h1);
		chk("bad addr", er, 1);
		chk("rom safe", rom_size_kb, 48);
	endtask
	initial begin
		{psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
		mem_addr = 16'h0000;
		ext_exp_en = 0;
		presetn = 0;
		t_reset;
		t_rom;
		t_xram;
		t_reset;
		final_report;
	end
endmodule
